/* inc/mcu_exec_pkg.sv */
// constants, opcodes, states and flag layout of the instruction execution unit
package mcu_exec_pkg;
  localparam int PC_W         = 11;
  localparam int IW           = 14;
  localparam int DW           = 8;
  localparam int DM_AW        = 7;
  localparam int STACK_LEVELS = 4;
  localparam int WDOG_W       = 8;
  // data memory address that aliases the program counter low byte
  localparam logic [DM_AW-1:0] PC_LOW_ADDR = 7'h02;
  localparam logic [2:0]       LAST_PAGE   = 3'h7;
  // instruction prefix in bits 13:12
  localparam logic [1:0] PFX_BRANCH = 2'h3;
  localparam logic [1:0] PFX_BIT    = 2'h2;
  // bit operation kind in bits 11:10
  localparam logic [1:0] BIT_CLEAR     = 2'h0;
  localparam logic [1:0] BIT_SKIP_ZERO = 2'h1;
  localparam logic [1:0] BIT_SKIP_SET  = 2'h2;
  // register port word indices
  localparam logic [2:0] BUS_CTRL     = 3'h0;
  localparam logic [2:0] BUS_ACCUM    = 3'h1;
  localparam logic [2:0] BUS_STATUS   = 3'h2;
  localparam logic [2:0] BUS_TABLE_HI = 3'h3;
  localparam logic [2:0] BUS_PC_LOW   = 3'h4;
  localparam logic [2:0] BUS_WDOG     = 3'h5;
  localparam int         CTRL_RUN_BIT = 0;
  localparam logic [7:0] CTRL_RESET   = 8'h01;
  localparam logic [5:0] FLAGS_RESET  = 6'h00;

  typedef enum logic [4:0] {
    OP_NOP, OP_ADD_CARRY_ACCUM, OP_ADD_CARRY_MEM, OP_ADD_ACCUM, OP_ADD_IMM,
    OP_ADD_MEM, OP_AND_ACCUM, OP_AND_IMM, OP_AND_MEM, OP_CLEAR_MEM,
    OP_COMPL_MEM, OP_COMPL_ACCUM, OP_SKIP_ZERO, OP_SKIP_ZERO_MOVE, OP_INC_SKIP,
    OP_DEC_SKIP, OP_INC_SKIP_ACCUM, OP_DEC_SKIP_ACCUM, OP_SWAP_MEM, OP_SWAP_ACCUM,
    OP_RETURN, OP_RETURN_VALUE, OP_RETURN_INT, OP_TABLE_CURRENT, OP_TABLE_LAST,
    OP_WDOG_SINGLE, OP_WDOG_HALF_A, OP_WDOG_HALF_B, OP_HALT
  } op_e;

  typedef enum {ST_EXEC, ST_SKIP, ST_DUMMY, ST_TABLE, ST_HALTED} state_e;
  typedef enum {HALF_NONE, HALF_A, HALF_B} half_e;

  typedef struct packed {
    logic timeout;
    logic powerDown;
    logic overflow;
    logic zero;
    logic halfCarry;
    logic carry;
  } flags_s;
endpackage

/* rtl/mcu_instruction_execute_unit.sv */
// instruction fetch, decode and execute of the 8-bit core
`timescale 1ns/1ps
//
// Operation
// RULE1: skip taken costs two cycles, else one
// RULE2: writing program counter low byte takes two
// RULE3: single watchdog clear resets counter and flags
// RULE4: alternating half clears together clear watchdog
// RULE5: repeated same half clear changes nothing
// RULE6: add with carry, flags updated
// RULE7: plain add, memory or immediate, flags
// RULE8: logical and affects zero flag only
// RULE9: call pushes pc plus one, two cycles
// RULE10: clear memory byte writes zero, no flags
// RULE11: bit clear forces one bit low
// RULE12: memory complement in place, zero flag
// RULE13: table read fills high register and memory
// RULE14: increment or decrement, skip on zero
// RULE15: bit test skips on zero or set
// RULE16: nibble swap in place or to accumulator
// RULE17: return with value loads accumulator
// RULE18: halt stops, clears watchdog, sets power-down
// RULE19: return from interrupt sets interrupt enable
// RULE20: zero flag follows eight-bit result
// RULE21: half-carry bit3, carry bit7, signed overflow
module mcu_instruction_execute_unit
  import mcu_exec_pkg::*;
#(
  parameter int STACK_DEPTH = STACK_LEVELS,
  parameter int DM_DEPTH    = 128
)(
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst,
  // program memory
  output logic [PC_W-1:0]      progAddr,
  input  wire logic [IW-1:0]   progData,
  // core events
  input  wire logic            wakeUp,
  input  wire logic            watchdogTimeout,
  input  wire logic            interruptTaken,
  output logic                 powerDown,
  output logic                 masterIntEnable,
  output logic                 watchdogClear,
  // register port
  input  wire logic [2:0]      busAddr,
  input  wire logic [DW-1:0]   busWdata,
  input  wire logic            busWrite,
  input  wire logic            busRead,
  output logic [DW-1:0]        busRdata
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  state_e                  state_reg;
  state_e                  stateNext;
  half_e                   lastHalf_reg;
  flags_s                  flags_reg;
  logic [PC_W-1:0]         pc_reg;
  logic [PC_W-1:0]         pcNext;
  logic [DW-1:0]           accum_reg;
  logic [IW-1:0]           tableHigh_reg;
  logic [PC_W-1:0]         tableAddr_reg;
  logic [DM_AW-1:0]        tableDest_reg;
  logic [WDOG_W-1:0]       watchdogCnt_reg;
  logic [DW-1:0]           ctrl_reg;
  logic [DW-1:0]           dataMem [DM_DEPTH];
  logic [PC_W-1:0]         stack_reg [STACK_DEPTH];
  logic [SP_W-1:0]         sp_reg;
  logic                    intEnable_reg;
  logic                    wdogClear_reg;
  logic [DW-1:0]           busRdata_reg;

  // decode
  wire logic               go        = (state_reg == ST_EXEC) && ctrl_reg[CTRL_RUN_BIT];
  wire logic               isBranch  = progData[13:12] == PFX_BRANCH;
  wire logic               isCall    = isBranch && progData[11];
  wire logic               isBitOp   = progData[13:12] == PFX_BIT;
  wire logic [1:0]         bitKind   = progData[11:10];
  wire logic [DW-1:0]      bitMask   = 8'h01 << progData[9:7];
  wire op_e                opSel     = progData[13] ? OP_NOP : op_e'(progData[12:8]);
  wire logic [DM_AW-1:0]   memAddr   = progData[DM_AW-1:0];
  wire logic [DW-1:0]      imm       = progData[7:0];
  wire logic [PC_W-1:0]    jumpTarget = progData[PC_W-1:0];
  wire logic [PC_W-1:0]    pcInc     = pc_reg + PC_W'(1);
  wire logic [SP_W-1:0]    spTop     = sp_reg - SP_W'(1);
  wire logic [DW-1:0]      memRd     = (memAddr == PC_LOW_ADDR) ? pc_reg[7:0] : dataMem[memAddr];
  wire logic               useImm    = (opSel == OP_ADD_IMM) || (opSel == OP_AND_IMM);
  wire logic [DW-1:0]      opB       = useImm ? imm : memRd;
  wire logic               withCarry = (opSel == OP_ADD_CARRY_ACCUM) ||
                                       (opSel == OP_ADD_CARRY_MEM);
  wire logic               addCin    = withCarry && flags_reg.carry;
  wire logic [DW:0]        addSum    = {1'b0, accum_reg} + {1'b0, opB} + 9'(addCin);
  wire logic [4:0]         halfSum   = {1'b0, accum_reg[3:0]} + {1'b0, opB[3:0]} + 5'(addCin);
  wire logic               addOv     = (accum_reg[7] == opB[7]) && (addSum[7] != accum_reg[7]);

  logic [DW-1:0]           resVal;
  logic                    wrAccum;
  logic                    wrMem;
  logic                    setZero;
  logic                    setArith;
  logic                    isSkipOp;
  logic                    skipCond;
  logic                    doReturn;

  always_comb
  begin
    resVal   = memRd;
    wrAccum  = 1'b0;
    wrMem    = 1'b0;
    setZero  = 1'b0;
    setArith = 1'b0;
    isSkipOp = 1'b0;
    skipCond = 1'b0;
    doReturn = 1'b0;
    case (opSel)
      OP_ADD_CARRY_ACCUM, OP_ADD_ACCUM, OP_ADD_IMM:
      begin
        resVal   = addSum[7:0];  // see RULE6 see RULE7
        wrAccum  = 1'b1;
        setArith = 1'b1;
      end
      OP_ADD_CARRY_MEM, OP_ADD_MEM:
      begin
        resVal   = addSum[7:0];  // see RULE6 see RULE7
        wrMem    = 1'b1;
        setArith = 1'b1;
      end
      OP_AND_ACCUM, OP_AND_IMM, OP_AND_MEM:
      begin
        resVal   = accum_reg & opB;  // see RULE8
        wrAccum  = opSel != OP_AND_MEM;
        wrMem    = opSel == OP_AND_MEM;
        setZero  = 1'b1;
      end
      OP_CLEAR_MEM:
      begin
        resVal = 8'h00;  // see RULE10
        wrMem  = 1'b1;
      end
      OP_COMPL_MEM, OP_COMPL_ACCUM:
      begin
        resVal  = ~memRd;  // see RULE12
        wrMem   = opSel == OP_COMPL_MEM;
        wrAccum = opSel == OP_COMPL_ACCUM;
        setZero = 1'b1;
      end
      OP_SKIP_ZERO, OP_SKIP_ZERO_MOVE:
      begin
        isSkipOp = 1'b1;
        skipCond = memRd == 8'h00;
        wrAccum  = opSel == OP_SKIP_ZERO_MOVE;
      end
      OP_INC_SKIP, OP_INC_SKIP_ACCUM, OP_DEC_SKIP, OP_DEC_SKIP_ACCUM:
      begin
        resVal   = ((opSel == OP_INC_SKIP) || (opSel == OP_INC_SKIP_ACCUM)) ?
                   memRd + 8'h01 : memRd - 8'h01;  // see RULE14
        wrMem    = (opSel == OP_INC_SKIP) || (opSel == OP_DEC_SKIP);
        wrAccum  = !wrMem;
        isSkipOp = 1'b1;
        skipCond = resVal == 8'h00;
      end
      OP_SWAP_MEM, OP_SWAP_ACCUM:
      begin
        resVal  = {memRd[3:0], memRd[7:4]};  // see RULE16
        wrMem   = opSel == OP_SWAP_MEM;
        wrAccum = opSel == OP_SWAP_ACCUM;
      end
      OP_RETURN_VALUE:
      begin
        resVal   = imm;  // see RULE17
        wrAccum  = 1'b1;
        doReturn = 1'b1;
      end
      OP_RETURN, OP_RETURN_INT:
        doReturn = 1'b1;
      default:
        resVal = memRd;
    endcase
    if (isBitOp)
    begin
      isSkipOp = bitKind != BIT_CLEAR;  // see RULE15
      skipCond = (bitKind == BIT_SKIP_SET) == ((memRd & bitMask) != 8'h00);
      wrMem    = bitKind == BIT_CLEAR;
      resVal   = memRd & ~bitMask;  // see RULE11
    end
  end

  wire logic  pcLowWrite = wrMem && (memAddr == PC_LOW_ADDR);
  wire logic  doSkip     = isSkipOp && skipCond;
  wire logic  isTable    = (opSel == OP_TABLE_CURRENT) || (opSel == OP_TABLE_LAST);
  wire logic  isHalt     = opSel == OP_HALT;
  wire logic  pairDone   = ((opSel == OP_WDOG_HALF_A) && (lastHalf_reg == HALF_B)) ||
                           ((opSel == OP_WDOG_HALF_B) && (lastHalf_reg == HALF_A));
  wire logic  wdClr      = go && ((opSel == OP_WDOG_SINGLE) || pairDone);  // see RULE3 see RULE4
  wire logic  haltNow    = go && isHalt;

  // sequencing and program counter
  always_comb
  begin
    stateNext = state_reg;
    pcNext    = pc_reg;
    case (state_reg)
      ST_EXEC:
        if (go)
        begin
          pcNext = pcInc;
          if (isBranch)
            pcNext = jumpTarget;
          else if (doReturn)
            pcNext = stack_reg[spTop];
          else if (pcLowWrite)
            pcNext = {pc_reg[PC_W-1:8], resVal};
          if (isHalt)
            stateNext = ST_HALTED;  // see RULE18
          else if (isTable)
            stateNext = ST_TABLE;  // see RULE13
          else if (doSkip)
            stateNext = ST_SKIP;  // see RULE1
          else if (isBranch || doReturn || pcLowWrite)
            stateNext = ST_DUMMY;  // see RULE2 see RULE9
        end
      ST_SKIP:
      begin
        pcNext    = pcInc;
        stateNext = ST_EXEC;
      end
      ST_DUMMY, ST_TABLE:
        stateNext = ST_EXEC;
      ST_HALTED:
        if (wakeUp)
          stateNext = ST_EXEC;
      default:
        stateNext = ST_EXEC;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_EXEC;
      pc_reg    <= '0;
    end
    else
    begin
      state_reg <= stateNext;
      pc_reg    <= pcNext;
    end
  end

  // accumulator, flags and table registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      accum_reg     <= '0;
      flags_reg     <= FLAGS_RESET;
      tableHigh_reg <= '0;
      tableAddr_reg <= '0;
      tableDest_reg <= '0;
    end
    else
    begin
      if (go && wrAccum)
        accum_reg <= resVal;
      if (go && (setZero || setArith))
        flags_reg.zero <= resVal == 8'h00;  // see RULE20
      if (go && setArith)
      begin
        flags_reg.carry     <= addSum[DW];  // see RULE21
        flags_reg.halfCarry <= halfSum[4];
        flags_reg.overflow  <= addOv;
      end
      if (wdClr)
        flags_reg.powerDown <= 1'b0;
      else if (haltNow)
        flags_reg.powerDown <= 1'b1;
      if (watchdogTimeout)
        flags_reg.timeout <= 1'b1;
      else if (wdClr || haltNow)
        flags_reg.timeout <= 1'b0;
      if (go && isTable)
      begin
        tableAddr_reg <= {(opSel == OP_TABLE_LAST) ? LAST_PAGE : pc_reg[PC_W-1:8], accum_reg};
        tableDest_reg <= memAddr;
      end
      if (state_reg == ST_TABLE)
        tableHigh_reg <= {{DW{1'b0}}, progData[IW-1:DW]};  // see RULE13
    end
  end

  // data memory
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < DM_DEPTH; i++)
        dataMem[i] <= '0;
    end
    else if (go && wrMem && !pcLowWrite)
      dataMem[memAddr] <= resVal;
    else if (state_reg == ST_TABLE)
      dataMem[tableDest_reg] <= progData[7:0];
  end

  // return stack
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sp_reg <= '0;
      for (int i = 0; i < STACK_DEPTH; i++)
        stack_reg[i] <= '0;
    end
    else if (go && isCall)
    begin
      stack_reg[sp_reg] <= pcInc;  // see RULE9
      sp_reg            <= sp_reg + SP_W'(1);
    end
    else if (go && doReturn)
      sp_reg <= spTop;
  end

  // watchdog, interrupt enable, control
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      watchdogCnt_reg <= '0;
      lastHalf_reg    <= HALF_NONE;
      intEnable_reg   <= 1'b0;
      wdogClear_reg   <= 1'b0;
      ctrl_reg        <= CTRL_RESET;
      busRdata_reg    <= '0;
    end
    else
    begin
      if (wdClr || haltNow)
        watchdogCnt_reg <= '0;
      else if (state_reg != ST_HALTED)
        watchdogCnt_reg <= watchdogCnt_reg + WDOG_W'(1);
      wdogClear_reg <= wdClr || haltNow;
      if (go && (opSel == OP_WDOG_HALF_A))
        lastHalf_reg <= pairDone ? HALF_NONE : HALF_A;  // see RULE5
      else if (go && (opSel == OP_WDOG_HALF_B))
        lastHalf_reg <= pairDone ? HALF_NONE : HALF_B;
      if (go && (opSel == OP_RETURN_INT))
        intEnable_reg <= 1'b1;  // see RULE19
      else if (interruptTaken)
        intEnable_reg <= 1'b0;
      if (busWrite && (busAddr == BUS_CTRL))
        ctrl_reg <= busWdata;
      busRdata_reg <= '0;
      if (busRead)
        case (busAddr)
          BUS_CTRL:     busRdata_reg <= ctrl_reg;
          BUS_ACCUM:    busRdata_reg <= accum_reg;
          BUS_STATUS:   busRdata_reg <= {2'b00, flags_reg};
          BUS_TABLE_HI: busRdata_reg <= tableHigh_reg[DW-1:0];
          BUS_PC_LOW:   busRdata_reg <= pc_reg[7:0];
          BUS_WDOG:     busRdata_reg <= watchdogCnt_reg;
          default:      busRdata_reg <= '0;
        endcase
    end
  end

  assign progAddr        = (state_reg == ST_TABLE) ? tableAddr_reg : pc_reg;
  assign powerDown       = state_reg == ST_HALTED;
  assign masterIntEnable = intEnable_reg;
  assign watchdogClear   = wdogClear_reg;
  assign busRdata        = busRdata_reg;

  a_skip_two_cycles: assert property (@(posedge clk) disable iff (rst) // see RULE1
    (go && doSkip && !isTable && !isHalt) |=> (state_reg == ST_SKIP) ##1 (state_reg == ST_EXEC))
    else $error("taken skip did not last two cycles");
  a_noskip_one_cycle: assert property (@(posedge clk) disable iff (rst) // see RULE1
    (go && isSkipOp && !skipCond && !pcLowWrite) |=> (state_reg == ST_EXEC)
      && (pc_reg == $past(pcInc)))
    else $error("untaken skip did not last one cycle");
  a_pc_low_dummy: assert property (@(posedge clk) disable iff (rst) // see RULE2
    (go && pcLowWrite && !isSkipOp) |=> (state_reg == ST_DUMMY) && (pc_reg[7:0] == $past(resVal)))
    else $error("program counter low write not two cycles");
  a_single_clear: assert property (@(posedge clk) disable iff (rst) // see RULE3
    (go && (opSel == OP_WDOG_SINGLE) && !watchdogTimeout) |=>
      (watchdogCnt_reg == '0) && !flags_reg.timeout && !flags_reg.powerDown)
    else $error("single watchdog clear incomplete");
  a_half_pair_clear: assert property (@(posedge clk) disable iff (rst) // see RULE4
    (go && pairDone && !watchdogTimeout) |=> (watchdogCnt_reg == '0) && !flags_reg.timeout
      && !flags_reg.powerDown && (lastHalf_reg == HALF_NONE))
    else $error("alternating half clears had no effect");
  a_half_repeat_none: assert property (@(posedge clk) disable iff (rst) // see RULE5
    (go && (opSel == OP_WDOG_HALF_A) && (lastHalf_reg != HALF_B) && !watchdogTimeout) |=>
      $stable(flags_reg) && (watchdogCnt_reg == $past(watchdogCnt_reg) + WDOG_W'(1)))
    else $error("repeated half clear changed watchdog state");
  a_add_flags: assert property (@(posedge clk) disable iff (rst) // see RULE21
    (go && setArith) |=> (flags_reg.carry == $past(addSum[DW]))
      && (flags_reg.halfCarry == $past(halfSum[4])) && (flags_reg.overflow == $past(addOv)))
    else $error("addition flags wrong");
  a_zero_flag: assert property (@(posedge clk) disable iff (rst) // see RULE20
    (go && (setZero || setArith)) |=> flags_reg.zero == ($past(resVal) == 8'h00))
    else $error("zero flag does not follow result");
  a_call_push: assert property (@(posedge clk) disable iff (rst) // see RULE9
    (go && isCall) |=> (stack_reg[$past(sp_reg)] == $past(pcInc))
      && (pc_reg == $past(jumpTarget)) && (state_reg == ST_DUMMY) ##1 (state_reg == ST_EXEC))
    else $error("call did not push return address");
  a_halt_entry: assert property (@(posedge clk) disable iff (rst) // see RULE18
    (haltNow && !watchdogTimeout) |=> powerDown && flags_reg.powerDown
      && !flags_reg.timeout && (watchdogCnt_reg == '0))
    else $error("halt entry incomplete");
endmodule

/* tb/prog_rom_model.sv */
// combinational program memory model feeding the core
`timescale 1ns/1ps
module prog_rom_model
  import mcu_exec_pkg::*;
(
  // fetch port
  input  wire logic [PC_W-1:0] progAddr,
  output logic [IW-1:0]        progData
);
  // bench loads words directly; unloaded words are no-operations
  logic [IW-1:0] words [0:(1<<PC_W)-1];

  initial
  begin
    for (int j = 0; j < (1 << PC_W); j++)
      words[j] = '0;
  end

  assign progData = words[progAddr];
endmodule

/* tb/test_mcu_instruction_execute_unit.sv */
// self-checking bench for the instruction execution unit
`timescale 1ns/1ps
module test_mcu_instruction_execute_unit
  import mcu_exec_pkg::*;
;
  typedef struct {string name; logic [7:0] val;} note_s;

  logic            clk;
  logic            rst;
  logic [PC_W-1:0] progAddr;
  logic [IW-1:0]   progData;
  logic            wakeUp;
  logic            watchdogTimeout;
  logic            interruptTaken;
  logic            powerDown;
  logic            masterIntEnable;
  logic            watchdogClear;
  logic [2:0]      busAddr;
  logic [DW-1:0]   busWdata;
  logic            busWrite;
  logic            busRead;
  logic [DW-1:0]   busRdata;
  logic            rdSeen;
  note_s           expQ[$];
  note_s           got;
  logic [IW-1:0]   prog[$];
  int              error_cnt;
  int              n_checks;
  int              clrPulses;
  int              cycles;

  mcu_instruction_execute_unit #(.STACK_DEPTH(STACK_LEVELS), .DM_DEPTH(128)) DUT (
    .clk(clk), .rst(rst), .progAddr(progAddr), .progData(progData), .wakeUp(wakeUp),
    .watchdogTimeout(watchdogTimeout), .interruptTaken(interruptTaken),
    .powerDown(powerDown), .masterIntEnable(masterIntEnable),
    .watchdogClear(watchdogClear), .busAddr(busAddr), .busWdata(busWdata),
    .busWrite(busWrite), .busRead(busRead), .busRdata(busRdata));

  prog_rom_model rom (.progAddr(progAddr), .progData(progData));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [IW-1:0] enc(op_e o, logic [7:0] v);
    return {1'b0, o, v};
  endfunction

  function automatic logic [IW-1:0] bitOp(logic [1:0] kind, logic [2:0] b, logic [6:0] a);
    return {PFX_BIT, kind, b, a};
  endfunction

  function automatic logic [IW-1:0] br(logic isCall, logic [PC_W-1:0] t);
    return {PFX_BRANCH, isCall, t};
  endfunction

  // {overflow, zero, halfCarry, carry, sum}
  function automatic logic [11:0] addf(logic [7:0] x, logic [7:0] y, logic ci);
    logic [8:0] s;
    logic [4:0] h;
    s = x + y + ci;
    h = x[3:0] + y[3:0] + ci;
    return {(x[7] == y[7]) && (s[7] != x[7]), s[7:0] == 8'h00, h[4], s[8], s[7:0]};
  endfunction

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] seen);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task automatic busRd(input logic [2:0] a, input string nm, input logic [7:0] exp);
    expQ.push_back('{nm, exp});
    busAddr <= a;
    busRead <= 1'b1;
    @(posedge clk);
    busRead <= 1'b0;
    @(posedge clk);
  endtask

  task automatic busWr(input logic [2:0] a, input logic [7:0] d);
    busAddr  <= a;
    busWdata <= d;
    busWrite <= 1'b1;
    @(posedge clk);
    busWrite <= 1'b0;
    @(posedge clk);
  endtask

  task automatic load();
    for (int j = 0; j < (1 << PC_W); j++)
      rom.words[j] = '0;
    foreach (prog[j])
      rom.words[j] = prog[j];
  endtask

  // edges counted until power-down is seen before the edge
  task automatic waitHalt(output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (powerDown !== 1'b1 && n < 100);
  endtask

  task automatic startRun(input int expN);
    int n;
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    waitHalt(n);
    chk("cycles to halt", 8'(expN), 8'(n));
  endtask

  task automatic wake();
    int n;
    wakeUp <= 1'b1;
    @(posedge clk);
    wakeUp <= 1'b0;
    n = 0;
    while (powerDown === 1'b1 && n < 10)
    begin
      @(posedge clk);
      n++;
    end
    waitHalt(n);
  endtask

  // read answers and clear pulses are taken from the pre-edge values
  always @(posedge clk)
  begin
    if (rdSeen === 1'b1 && expQ.size() > 0)
    begin
      got = expQ.pop_front();
      chk(got.name, got.val, busRdata);
    end
    if (watchdogClear === 1'b1)
      clrPulses++;
    rdSeen <= busRead;
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  initial
  begin
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  k;
    logic [7:0]  m;
    logic [7:0]  acc;
    logic [11:0] r;
    logic [7:0]  st;
    int          w;
    rst = 1'b1;
    wakeUp = 1'b0;
    watchdogTimeout = 1'b0;
    interruptTaken = 1'b0;
    busAddr = 3'h0;
    busWdata = 8'h00;
    busWrite = 1'b0;
    busRead = 1'b0;
    rdSeen = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    clrPulses = 0;
    cycles = 0;
    void'($urandom(33431));
    for (int i = 0; i < 4; i++)
    begin
      a = 8'($urandom);
      b = 8'($urandom);
      k = $urandom_range(1) ? 8'($urandom) : 8'h00;
      prog = '{enc(OP_ADD_IMM, a), enc(OP_ADD_MEM, 8'h10), enc(OP_ADD_IMM, b),
               enc(OP_ADD_CARRY_ACCUM, 8'h10), enc(OP_COMPL_MEM, 8'h10),
               bitOp(BIT_CLEAR, 3'd0, 7'h10), enc(OP_SWAP_ACCUM, 8'h10), enc(OP_AND_IMM, k),
               enc(OP_HALT, 8'h00), enc(OP_CLEAR_MEM, 8'h10), enc(OP_SKIP_ZERO_MOVE, 8'h10),
               enc(OP_ADD_IMM, 8'h01), enc(OP_HALT, 8'h00)};
      load();
      r = addf(a, b, 1'b0);
      r = addf(r[7:0], a, r[8]);
      m = ~a & 8'hFE;
      acc = {m[3:0], m[7:4]} & k;
      st = {2'b00, 2'b01, r[11], acc == 8'h00, r[9], r[8]};
      startRun(10);
      busRd(BUS_ACCUM, "accumulator", acc);
      busRd(BUS_STATUS, "status", st);
      wake();
      busRd(BUS_ACCUM, "accumulator", 8'h00);
      busRd(BUS_STATUS, "status", st);
    end
    prog = '{enc(OP_SKIP_ZERO, 8'h14), enc(OP_ADD_IMM, 8'h55), enc(OP_INC_SKIP, 8'h15),
             bitOp(BIT_SKIP_SET, 3'd0, 7'h15), enc(OP_ADD_IMM, 8'h80),
             bitOp(BIT_SKIP_ZERO, 3'd0, 7'h15), br(1'b1, 11'h040), enc(OP_ADD_IMM, 8'h01),
             enc(OP_TABLE_CURRENT, 8'h16), enc(OP_SKIP_ZERO_MOVE, 8'h16), br(1'b1, 11'h048),
             br(1'b0, 11'h105)};
    load();
    rom.words[11'h040] = enc(OP_RETURN_VALUE, 8'h2F);
    rom.words[11'h048] = enc(OP_RETURN_INT, 8'h00);
    rom.words[11'h030] = 14'h2ABC;
    rom.words[11'h105] = enc(OP_CLEAR_MEM, {1'b0, PC_LOW_ADDR});
    rom.words[11'h100] = enc(OP_HALT, 8'h00);
    startRun(24);
    busRd(BUS_ACCUM, "accumulator", 8'hBC);
    busRd(BUS_TABLE_HI, "table high", 8'h2A);
    busRd(BUS_STATUS, "status", 8'h12);
    chk("masterIntEnable", 8'h01, {7'h00, masterIntEnable});
    interruptTaken <= 1'b1;
    @(posedge clk);
    interruptTaken <= 1'b0;
    @(posedge clk);
    chk("masterIntEnable", 8'h00, {7'h00, masterIntEnable});
    busWr(BUS_CTRL, 8'h00);
    busRd(BUS_CTRL, "control", 8'h00);
    busWr(BUS_ACCUM, 8'h77);
    busRd(BUS_ACCUM, "accumulator", 8'hBC);
    busRd(3'h6, "unmapped", 8'h00);
    busWr(BUS_CTRL, CTRL_RESET);
    busRd(BUS_CTRL, "control", CTRL_RESET);
    // remaining arithmetic, accumulator and memory variants, last-page table, run stall
    prog = '{enc(OP_ADD_IMM, 8'h3D), enc(OP_ADD_MEM, 8'h20), enc(OP_SWAP_MEM, 8'h20),
             enc(OP_ADD_ACCUM, 8'h20), enc(OP_ADD_CARRY_MEM, 8'h20), enc(OP_HALT, 8'h00),
             enc(OP_COMPL_ACCUM, 8'h20), enc(OP_HALT, 8'h00), enc(OP_AND_MEM, 8'h20),
             enc(OP_INC_SKIP_ACCUM, 8'h20), enc(OP_HALT, 8'h00), enc(OP_INC_SKIP, 8'h22),
             enc(OP_DEC_SKIP_ACCUM, 8'h22), enc(OP_ADD_IMM, 8'h80), enc(OP_HALT, 8'h00),
             enc(OP_DEC_SKIP, 8'h22), enc(OP_ADD_IMM, 8'h80), br(1'b1, 11'h050),
             enc(OP_TABLE_LAST, 8'h21), enc(OP_SKIP_ZERO_MOVE, 8'h21), enc(OP_HALT, 8'h00),
             enc(OP_AND_ACCUM, 8'h21), enc(OP_HALT, 8'h00)};
    load();
    rom.words[11'h050] = enc(OP_RETURN, 8'h00);
    rom.words[11'h700] = 14'h1D5A;
    startRun(7);
    busRd(BUS_ACCUM, "accumulator", 8'h10);
    busRd(BUS_STATUS, "status", 8'h10);
    wake();
    busRd(BUS_ACCUM, "accumulator", 8'h1B);
    wake();
    busRd(BUS_ACCUM, "accumulator", 8'h01);
    busRd(BUS_STATUS, "status", 8'h14);
    wake();
    busRd(BUS_ACCUM, "accumulator", 8'h00);
    wake();
    busRd(BUS_ACCUM, "accumulator", 8'h5A);
    busRd(BUS_TABLE_HI, "table high", 8'h1D);
    busRd(BUS_STATUS, "status", 8'h14);
    busWr(BUS_CTRL, 8'h00);
    wake();
    busRd(BUS_PC_LOW, "program counter low", 8'h15);
    busWr(BUS_CTRL, CTRL_RESET);
    waitHalt(w);
    chk("cycles to halt", 8'd2, 8'(w));
    busRd(BUS_ACCUM, "accumulator", 8'h5A);
    busRd(BUS_STATUS, "status", 8'h10);
    prog = '{enc(OP_HALT, 8'h00), enc(OP_WDOG_HALF_A, 8'h00), enc(OP_WDOG_HALF_A, 8'h00),
             enc(OP_WDOG_HALF_B, 8'h00), enc(OP_WDOG_HALF_B, 8'h00),
             enc(OP_WDOG_SINGLE, 8'h00), enc(OP_HALT, 8'h00)};
    load();
    startRun(2);
    watchdogTimeout <= 1'b1;
    @(posedge clk);
    watchdogTimeout <= 1'b0;
    @(posedge clk);
    busRd(BUS_STATUS, "status", 8'h30);
    busRd(BUS_WDOG, "watchdog counter", 8'h00);
    clrPulses = 0;
    wake();
    @(posedge clk);
    chk("clear pulses", 8'd3, 8'(clrPulses));
    busRd(BUS_STATUS, "status", 8'h10);
    repeat (3) @(posedge clk);
    chk("pending reads", 8'h00, 8'(expQ.size()));
    stop_test();
  end
endmodule
